/* File: src/ddp_ctrl.sv */
// ddp_ctrl: two-wire slave and register bank of a dual 64-tap potentiometer
// assumes: scl_i is a clock port made by the master; sda is open drain outside;
// address select and write-guard pins are static straps, synchronised here
`timescale 1ns/10ps
// Function
// - each channel has own 6-bit wiper register
// - four 6-bit stored slots per channel
// - slot zero loads wiper at power-up
// - guard low blocks slot writes, wiper allowed
// - guard high permits all operations
// - respond only when address matches select pins
// - four select pins, bit zero least significant
// - data line driven only as open drain
// - master clock times all transfers
// - exactly one tap connected per channel
// - wiper and slots readable and writable
// - commands copy wiper and slot both ways
// - increment/decrement mode steps wiper
// - wiper is tap index 0 to 63
module ddp_ctrl
  import ddp_pkg::*;
#(
  parameter int unsigned TAP_COUNT = ddp_pkg::TAPS
) (
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                scl_i,
  input  wire logic                                sda_i,
  output logic                                     sda_o,
  output logic                                     sda_oe_n_o,
  input  wire logic [ddp_pkg::ADDR_SEL_W-1:0]      address_select_i,
  input  wire logic                                write_guard_n_i,
  output logic      [ddp_pkg::WIPER_W-1:0]         wiper_terminal_ch0_o,
  output logic      [ddp_pkg::WIPER_W-1:0]         wiper_terminal_ch1_o,
  output logic      [TAP_COUNT-1:0]                tap_sel_ch0_o,
  output logic      [TAP_COUNT-1:0]                tap_sel_ch1_o
);
  import ddp_pkg::*;

  // ---------------- link domain (scl_i) ----------------
  typedef enum logic [2:0] {
    DDP_IDLE, DDP_ADDR, DDP_CMD, DDP_DATA, DDP_RDATA, DDP_ACK, DDP_RACK
  } ddp_state_t;

  ddp_state_t     st_q,  st_d;
  logic [7:0]     sh_q,  sh_d;
  logic [2:0]     bit_q, bit_d;
  // the link domain has no reset of its own: these start at their idle
  // levels so the bus is released and no false request fires at power-up
  logic           ack_q = 1'b0;     // device pulls data low (level held from one scl fall to the next)
  logic           ack_d;
  logic           out_q = 1'b1;     // read bit to drive (0 pulls low)
  logic           out_d;
  logic           rd_q,  rd_d;
  logic           have_cmd_q, have_cmd_d;
  logic [7:0]     cmd_q, cmd_d;
  logic [7:0]     data_q, data_d;
  logic           req_tgl_q = 1'b0; // flips once per request to the core domain
  logic           req_tgl_d;
  ddp_state_t     nxt_q, nxt_d;
  logic           start_seen;
  logic           stop_seen;

  // start and stop are data edges while scl is high; seen on sda edges
  // each condition flips a toggle; the next scl rise compares it with its
  // copy, so a condition is taken once however long the bus then idles
  logic start_tgl_q = 1'b0;
  logic stop_tgl_q  = 1'b0;
  always_ff @(negedge sda_i) begin
    if (scl_i) start_tgl_q <= ~start_tgl_q;
  end
  always_ff @(posedge sda_i) begin
    if (scl_i) stop_tgl_q <= ~stop_tgl_q;
  end
  // both sides start equal, so no condition is seen before the first edge
  logic start_ack_q = 1'b0;
  logic stop_ack_q  = 1'b0;
  always_ff @(posedge scl_i) begin
    start_ack_q <= start_tgl_q;
    stop_ack_q  <= stop_tgl_q;
  end
  assign start_seen = start_ack_q != start_tgl_q;
  assign stop_seen  = stop_ack_q  != stop_tgl_q;

  logic [ADDR_SEL_W-1:0] addr_sel_s;  // straps, static during frames
  logic                  guard_s;
  logic [7:0]            rd_byte;

  always_comb begin
    st_d       = st_q;
    sh_d       = sh_q;
    bit_d      = bit_q;
    ack_d      = 1'b0;
    out_d      = 1'b1;
    rd_d       = rd_q;
    have_cmd_d = have_cmd_q;
    cmd_d      = cmd_q;
    data_d     = data_q;
    req_tgl_d  = req_tgl_q;
    nxt_d      = nxt_q;
    if (start_seen) begin
      st_d  = DDP_ADDR;
      sh_d  = {7'h00, sda_i};
      bit_d = 3'h1;
      have_cmd_d = 1'b0;
    end else if (stop_seen) begin
      st_d = DDP_IDLE;
    end else begin
      case (st_q)
        DDP_ADDR, DDP_CMD, DDP_DATA: begin
          sh_d  = {sh_q[6:0], sda_i};
          bit_d = bit_q + 3'h1;
          // the start branch took the first address bit, so the eighth bit of
          // every byte arrives with bit_q at seven
          if (bit_q == 3'h7) begin
            if (st_q == DDP_ADDR) begin
              if (sh_d[7:5] == DEV_TYPE_ID[2:0] && sh_d[4:1] == addr_sel_s) begin
                rd_d  = sh_d[0];
                st_d  = DDP_ACK;
                nxt_d = sh_d[0] ? DDP_RDATA : DDP_CMD;
              end else begin
                st_d = DDP_IDLE;
              end
            end else if (st_q == DDP_CMD) begin
              cmd_d = sh_d;
              st_d  = DDP_ACK;
              nxt_d = DDP_DATA;
              have_cmd_d = 1'b1;
              if (sh_d[CMD_OP_HI:CMD_OP_LO] == OP_SLOT_TO_W ||
                  sh_d[CMD_OP_HI:CMD_OP_LO] == OP_W_TO_SLOT) begin
                req_tgl_d = ~req_tgl_q;
              end
            end else begin
              data_d    = sh_d;
              st_d      = DDP_ACK;
              nxt_d     = DDP_DATA;
              req_tgl_d = ~req_tgl_q;
            end
          end
        end
        DDP_ACK: begin
          // the acknowledge slot itself: pull low from this fall to the next
          ack_d = 1'b1;
          bit_d = 3'h0;
          st_d  = nxt_q;
        end
        DDP_RDATA: begin
          // bit_q counts the bit about to go out, most significant first
          out_d = rd_byte[3'h7 - bit_q];
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_d = DDP_RACK;
          end
        end
        DDP_RACK: begin
          // line released for the master acknowledge: low reads on, high ends
          st_d  = sda_i ? DDP_IDLE : DDP_RDATA;
          bit_d = 3'h0;
        end
        default: st_d = DDP_IDLE;
      endcase
    end
  end

  always_ff @(posedge scl_i) begin
    st_q       <= st_d;
    sh_q       <= sh_d;
    bit_q      <= bit_d;
    rd_q       <= rd_d;
    have_cmd_q <= have_cmd_d;
    cmd_q      <= cmd_d;
    data_q     <= data_d;
    req_tgl_q  <= req_tgl_d;
    nxt_q      <= nxt_d;
  end

  // drive changes on the falling edge so data is stable while scl is high
  always_ff @(negedge scl_i) begin
    ack_q <= ack_d;
    out_q <= (st_q == DDP_RDATA || st_q == DDP_ACK || st_q == DDP_RACK) ? out_d : 1'b1;
  end

  // ---------------- core domain (clk_i) ----------------
  logic [WIPER_W-1:0] wiper_q [NUM_CH];
  logic [WIPER_W-1:0] wiper_d [NUM_CH];
  // stored slots model nonvolatile cells: blank at power-on, untouched by reset
  logic [WIPER_W-1:0] slot_q  [NUM_CH][NUM_SLOTS] = '{default: SLOT_RESET};
  logic [WIPER_W-1:0] slot_d  [NUM_CH][NUM_SLOTS];
  logic               boot_q, boot_d;
  logic [2:0]         req_sync_q;
  logic               sda_oe_n_q;
  logic [WIPER_W-1:0] w0_q, w1_q;

  // saturating step: the end taps hold rather than wrap around
  function automatic logic [WIPER_W-1:0] step_sat(input logic [WIPER_W-1:0] w,
                                                 input logic up);
    if (up) step_sat = (w == TAP_MAX) ? TAP_MAX : w + 6'h01;
    else    step_sat = (w == TAP_MIN) ? TAP_MIN : w - 6'h01;
  endfunction : step_sat

  ddp_sync u_guard_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .d_i       (write_guard_n_i),
    .rst_val_i (1'b1),
    .q_o       (guard_s)
  );

  // straps pass two stages; the request toggle passes three and the third
  // stage is compared with the second to make a one-cycle event
  logic [ADDR_SEL_W-1:0] addr_m_q, addr_s_q;
  always_ff @(posedge clk_i) begin
    addr_m_q   <= address_select_i;
    addr_s_q   <= addr_m_q;
    req_sync_q <= {req_sync_q[1:0], req_tgl_q};
  end
  assign addr_sel_s = addr_s_q;

  // read data is held in the core domain; static while the master reads
  assign rd_byte = {2'b00, (cmd_q[CMD_OP_HI:CMD_OP_LO] == OP_RD_SLOT)
                   ? slot_q[cmd_q[CMD_CH_POS]][cmd_q[CMD_SLOT_HI:CMD_SLOT_LO]]
                   : wiper_q[cmd_q[CMD_CH_POS]]};

  // one event per byte that asks for work
  logic       req_ev;
  logic       ch;
  logic [1:0] sl;
  logic [3:0] op;
  assign req_ev = req_sync_q[2] ^ req_sync_q[1];
  assign ch     = cmd_q[CMD_CH_POS];
  assign sl     = cmd_q[CMD_SLOT_HI:CMD_SLOT_LO];
  assign op     = cmd_q[CMD_OP_HI:CMD_OP_LO];

  // command and data words come from the link domain; they only change on a
  // byte boundary, long after the toggle that announces them is taken here.
  // power-up recall wins over a request in the same cycle
  always_comb begin
    wiper_d = wiper_q;
    slot_d  = slot_q;
    boot_d  = 1'b0;
    if (boot_q) begin
      for (int c = 0; c < NUM_CH; c++) wiper_d[c] = slot_q[c][0];
    end else if (req_ev) begin
      case (op)
        OP_WR_WIPER:  wiper_d[ch] = data_q[WIPER_W-1:0];
        OP_WR_SLOT:   if (guard_s) slot_d[ch][sl] = data_q[WIPER_W-1:0];
        OP_SLOT_TO_W: wiper_d[ch] = slot_q[ch][sl];
        OP_W_TO_SLOT: if (guard_s) slot_d[ch][sl] = wiper_q[ch];
        OP_INC_DEC:   wiper_d[ch] = step_sat(wiper_q[ch], data_q[0]);
        default:      ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // wipers read tap zero while reset is held; recall on the first free edge
      boot_q <= 1'b1;
      for (int c = 0; c < NUM_CH; c++) begin
        wiper_q[c] <= TAP_MIN;
      end
    end else begin
      boot_q  <= boot_d;
      wiper_q <= wiper_d;
    end
    slot_q <= slot_d; // nonvolatile model: survives reset
  end

  // sda: open drain, only ever pulled low
  // the drive flags cross in a single stage on purpose: a release must reach
  // the pin well inside the low half of scl, and both flags only move on its
  // falling edge, while the wire level matters to no one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_oe_n_q <= 1'b1;
      w0_q       <= TAP_MIN;
      w1_q       <= TAP_MIN;
    end else begin
      sda_oe_n_q <= ~(ack_q | ~out_q);
      w0_q       <= wiper_q[0];
      w1_q       <= wiper_q[1];
    end
  end

  assign sda_o                = 1'b0;
  assign sda_oe_n_o           = sda_oe_n_q;
  assign wiper_terminal_ch0_o = w0_q;
  assign wiper_terminal_ch1_o = w1_q;

  // tap selects are registered from the same wiper value as the terminal
  // outputs, so both move on one edge and never disagree
  ddp_tap_decode #(.W(WIPER_W), .TAPS(TAP_COUNT)) u_tap0 (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pos_i (wiper_q[0]),
    .tap_o (tap_sel_ch0_o)
  );
  ddp_tap_decode #(.W(WIPER_W), .TAPS(TAP_COUNT)) u_tap1 (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pos_i (wiper_q[1]),
    .tap_o (tap_sel_ch1_o)
  );
endmodule : ddp_ctrl

/* File: src/ddp_pkg.sv */
// ddp_pkg: constants and types shared by the dual potentiometer control block
// assumes: a two-wire bus slave in front of two 6-bit wiper registers
package ddp_pkg;
  localparam int unsigned WIPER_W      = 6;
  localparam int unsigned NUM_CH       = 2;
  localparam int unsigned NUM_SLOTS    = 4;
  localparam int unsigned TAPS         = 64;
  localparam int unsigned ADDR_SEL_W   = 4;
  localparam logic [WIPER_W-1:0] TAP_MIN = 6'h00;
  localparam logic [WIPER_W-1:0] TAP_MAX = 6'h3F;
  // fixed upper three bits of the slave address (arbitrary value)
  localparam logic [2:0] DEV_TYPE_ID  = 3'h5;
  // command byte: [7:4] opcode, [3:2] slot, [0] channel
  localparam int unsigned CMD_OP_HI   = 7;
  localparam int unsigned CMD_OP_LO   = 4;
  localparam int unsigned CMD_SLOT_HI = 3;
  localparam int unsigned CMD_SLOT_LO = 2;
  localparam int unsigned CMD_CH_POS  = 0;
  localparam logic [3:0] OP_RD_WIPER  = 4'h9;
  localparam logic [3:0] OP_WR_WIPER  = 4'hA;
  localparam logic [3:0] OP_RD_SLOT   = 4'hB;
  localparam logic [3:0] OP_WR_SLOT   = 4'hC;
  localparam logic [3:0] OP_SLOT_TO_W = 4'hD;
  localparam logic [3:0] OP_W_TO_SLOT = 4'hE;
  localparam logic [3:0] OP_INC_DEC   = 4'h2;
  // power-on values of stored slots (model of blank memory)
  localparam logic [WIPER_W-1:0] SLOT_RESET = 6'h20;
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    DDP_OP_NONE,
    DDP_OP_WR_WIPER,
    DDP_OP_WR_SLOT,
    DDP_OP_SLOT_TO_W,
    DDP_OP_W_TO_SLOT,
    DDP_OP_STEP
  } ddp_op_t;
endpackage : ddp_pkg

/* File: src/ddp_sync.sv */
// ddp_sync: two-stage synchroniser for a single level
// assumes: input is asynchronous to clk_i
`timescale 1ns/10ps
module ddp_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  input  wire logic rst_val_i,
  output logic      q_o
);
  logic meta_q;
  logic meta_d;
  logic q_q;
  logic q_d;

  always_comb begin
    meta_d = d_i;
    q_d    = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= rst_val_i;
      q_q    <= rst_val_i;
    end else begin
      meta_q <= meta_d;
      q_q    <= q_d;
    end
  end

  assign q_o = q_q;
endmodule : ddp_sync

/* File: src/ddp_tap_decode.sv */
// ddp_tap_decode: one-hot tap select from a wiper position, registered
// assumes: position is stable in clk_i domain
`timescale 1ns/10ps
module ddp_tap_decode #(
  parameter int unsigned W    = 6,
  parameter int unsigned TAPS = 64
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic [W-1:0]    pos_i,
  output logic      [TAPS-1:0] tap_o
);
  logic [TAPS-1:0] tap_q;
  logic [TAPS-1:0] tap_d;

  always_comb begin
    tap_d = '0;
    tap_d[pos_i] = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tap_q <= {{(TAPS-1){1'b0}}, 1'b1};
    end else begin
      tap_q <= tap_d;
    end
  end

  assign tap_o = tap_q;
endmodule : ddp_tap_decode

/* File: tb/ddp_asserts.sv */
// ddp_asserts: port checker for the dual potentiometer control block
// assumes: bound to ddp_ctrl, bus idles high with pull-up on sda
`timescale 1ns/10ps
module ddp_asserts
  import ddp_pkg::*;
#(
  parameter int unsigned TAP_COUNT = ddp_pkg::TAPS
) (
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         scl_i,
  input wire logic                         sda_i,
  input wire logic                         sda_o,
  input wire logic                         sda_oe_n_o,
  input wire logic [ddp_pkg::ADDR_SEL_W-1:0] address_select_i,
  input wire logic                         write_guard_n_i,
  input wire logic [ddp_pkg::WIPER_W-1:0]  wiper_terminal_ch0_o,
  input wire logic [ddp_pkg::WIPER_W-1:0]  wiper_terminal_ch1_o,
  input wire logic [TAP_COUNT-1:0]         tap_sel_ch0_o,
  input wire logic [TAP_COUNT-1:0]         tap_sel_ch1_o
);
  import ddp_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // serial bus quiet long enough that no frame is in flight
  sequence bus_idle;
    (scl_i && sda_i && !rst_i) [*8];
  endsequence
  AST_SDA_LOW: assert property (sda_o == 1'b0)
    else $error("sda output not low");
  AST_ONE_TAP0: assert property ($onehot(tap_sel_ch0_o))
    else $error("channel 0 tap select not one-hot");
  AST_ONE_TAP1: assert property ($onehot(tap_sel_ch1_o))
    else $error("channel 1 tap select not one-hot");
  AST_TAP_POS0: assert property ($stable(wiper_terminal_ch0_o) |-> tap_sel_ch0_o[wiper_terminal_ch0_o])
    else $error("channel 0 tap differs from wiper");
  AST_TAP_POS1: assert property ($stable(wiper_terminal_ch1_o) |-> tap_sel_ch1_o[wiper_terminal_ch1_o])
    else $error("channel 1 tap differs from wiper");
  AST_HOLD0: assert property (bus_idle |=> $stable(wiper_terminal_ch0_o))
    else $error("channel 0 wiper moved with bus idle");
  AST_HOLD1: assert property (bus_idle |=> $stable(wiper_terminal_ch1_o))
    else $error("channel 1 wiper moved with bus idle");
  AST_IDLE_REL: assert property ((scl_i && !rst_i) [*8] |-> sda_oe_n_o)
    else $error("sda held low with clock idle");
  cover property ($changed(wiper_terminal_ch0_o));
  cover property ($fell(sda_oe_n_o));
  cover property (wiper_terminal_ch1_o == TAP_MAX);
endmodule : ddp_asserts

bind ddp_ctrl ddp_asserts #(.TAP_COUNT(TAP_COUNT)) u_asserts (.clk_i(clk_i), .rst_i(rst_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .address_select_i(address_select_i), .write_guard_n_i(write_guard_n_i),
  .wiper_terminal_ch0_o(wiper_terminal_ch0_o), .wiper_terminal_ch1_o(wiper_terminal_ch1_o),
  .tap_sel_ch0_o(tap_sel_ch0_o), .tap_sel_ch1_o(tap_sel_ch1_o));

/* File: tb/ddp_bus_master.sv */
// ddp_bus_master: two-wire master model, 30 ns serial clock
// assumes: sda is pulled up and joined from both drive-low flags outside
`timescale 1ns/10ps
module ddp_bus_master (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  // clock stands high outside frames
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic start_c();
    sda_low_o = 1'b1;
    #15 scl_o = 1'b0;
  endtask : start_c
  task automatic stop_c();
    #7 sda_low_o = 1'b1;
    #8 scl_o = 1'b1;
    #7 sda_low_o = 1'b0;
    #15;
  endtask : stop_c
  // data moves while clock low, sampled late in the high phase
  task automatic bit_c(input logic b, output logic s);
    #7 sda_low_o = ~b;
    #8 scl_o = 1'b1;
    #14 s = sda_i;
    #1 scl_o = 1'b0;
  endtask : bit_c
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(b[i], s);
    bit_c(1'b1, s);
    ack = ~s;
  endtask : put_byte
  task automatic get_byte(output logic [7:0] b, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(1'b1, b[i]);
    bit_c(nack, s);
  endtask : get_byte
endmodule : ddp_bus_master

/* File: tb/testbench.sv */
// testbench: self-checking bench for the dual potentiometer control block
// assumes: checker bound to the design, bus master model beside it
`timescale 1ns/10ps
module testbench;
  import ddp_pkg::*;
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic [ADDR_SEL_W-1:0] a_sel = 4'h6;
  logic                  guard_n = 1'b1;
  logic                  scl, m_low, oe_n, sda_o, ok;
  logic [WIPER_W-1:0]    w0, w1;
  logic [TAPS-1:0]       t0, t1;
  logic [WIPER_W-1:0]    st[4] = '{6'h15, 6'h15, 6'h3F, 6'h00};
  logic [WIPER_W-1:0]    ex[4] = '{6'h16, 6'h14, 6'h3F, 6'h00};
  logic                  up[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int                    fails = 0;
  int                    check_count = 0;
  wire                   sda = ~(m_low | ~oe_n);
  always #4 clk_i = ~clk_i;
  ddp_bus_master bus (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
  ddp_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n_o(oe_n), .address_select_i(a_sel), .write_guard_n_i(guard_n),
    .wiper_terminal_ch0_o(w0), .wiper_terminal_ch1_o(w1), .tap_sel_ch0_o(t0),
    .tap_sel_ch1_o(t1));
  function automatic logic [7:0] cmd(logic [3:0] op, logic [1:0] slot, logic ch);
    return {op, slot, 1'b0, ch};
  endfunction : cmd
  task automatic chk_v(input logic [WIPER_W-1:0] got, input logic [WIPER_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : chk_v
  task automatic chk_a(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: ack %b expected %b", $time, got, exp);
    end
  endtask : chk_a
  task automatic frame(input logic [3:0] adr, input logic [7:0] c, input logic [7:0] d,
                       input logic wd);
    logic a;
    bus.start_c();
    bus.put_byte({DEV_TYPE_ID, adr, 1'b0}, ok);
    bus.put_byte(c, a);
    if (wd) bus.put_byte(d, a);
    bus.stop_c();
    repeat (8) @(posedge clk_i);
  endtask : frame
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    frame(a_sel, c, d, 1'b1);
    chk_a(ok, 1'b1);
  endtask : wr
  task automatic rd_chk(input logic [7:0] c, input logic [WIPER_W-1:0] exp);
    logic [7:0] d;
    frame(a_sel, c, 8'h00, 1'b0);
    bus.start_c();
    bus.put_byte({DEV_TYPE_ID, a_sel, 1'b1}, ok);
    bus.get_byte(d, 1'b1);
    bus.stop_c();
    chk_v(d[WIPER_W-1:0], exp);
  endtask : rd_chk
  task automatic rst_pulse();
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : rst_pulse
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    rst_pulse();
    chk_v(w0, SLOT_RESET);
    wr(cmd(OP_WR_WIPER, 2'h0, 1'b1), 8'h15);
    chk_v(w1, 6'h15);
    chk_v(w0, SLOT_RESET);
    rd_chk(cmd(OP_RD_WIPER, 2'h0, 1'b1), 6'h15);
    for (int i = 0; i < 4; i++) begin
      frame(a_sel ^ (4'h1 << i), cmd(OP_WR_WIPER, 2'h0, 1'b1), 8'h2A, 1'b1);
      chk_a(ok, 1'b0);
    end
    chk_v(w1, 6'h15);
    @(posedge clk_i) a_sel <= 4'h9;
    repeat (4) @(posedge clk_i);
    wr(cmd(OP_WR_SLOT, 2'h2, 1'b0), 8'h3A);
    rd_chk(cmd(OP_RD_SLOT, 2'h2, 1'b0), 6'h3A);
    rd_chk(cmd(OP_RD_SLOT, 2'h2, 1'b1), SLOT_RESET);
    @(posedge clk_i) guard_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(cmd(OP_WR_SLOT, 2'h2, 1'b0), 8'h01);
    wr(cmd(OP_WR_WIPER, 2'h0, 1'b0), 8'h07);
    wr(cmd(OP_W_TO_SLOT, 2'h2, 1'b0), 8'h00);
    rd_chk(cmd(OP_RD_SLOT, 2'h2, 1'b0), 6'h3A);
    chk_v(w0, 6'h07);
    @(posedge clk_i) guard_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr(cmd(OP_W_TO_SLOT, 2'h3, 1'b0), 8'h00);
    rd_chk(cmd(OP_RD_SLOT, 2'h3, 1'b0), 6'h07);
    wr(cmd(OP_SLOT_TO_W, 2'h2, 1'b0), 8'h00);
    chk_v(w0, 6'h3A);
    for (int i = 0; i < 4; i++) begin
      wr(cmd(OP_WR_WIPER, 2'h0, 1'b1), {2'b00, st[i]});
      wr(cmd(OP_INC_DEC, 2'h0, 1'b1), {7'h00, up[i]});
      chk_v(w1, ex[i]);
    end
    wr(cmd(OP_WR_SLOT, 2'h0, 1'b1), 8'h11);
    rst_pulse();
    chk_v(w1, 6'h11);
    chk_v(w0, SLOT_RESET);
    print_verdict();
  end
  initial begin
    #300000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : testbench
